// ---- hw/sync_receive_irq_crc_check.sv ----
// Sync receive channel: interrupt modes, latched errors and CRC check
`timescale 1ns/100ps
module sync_receive_irq_crc_check
  import sync_rx_pkg::*;
#(
  parameter bit SECOND_CHANNEL = 1'b1,
  parameter int DEPTH          = FIFO_DEPTH
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        receive_clock_pin,
  input  wire logic        rx_data_pin,
  input  wire logic        dcd_n_pin,
  output logic             irq_q,
  output logic [7:0]       vector_q,
  output logic             wait_ready_q
);

  // Three-stage samplers for pins
  logic [2:0] clk_s_q, dat_s_q, dcd_s_q;
  logic       rxc_q, dcd_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_s_q <= 3'b000;
      dat_s_q <= 3'b000;
      dcd_s_q <= 3'b111;
      rxc_q   <= 1'b0;
      dcd_q   <= 1'b1;
    end else begin
      clk_s_q <= {clk_s_q[1:0], receive_clock_pin};
      dat_s_q <= {dat_s_q[1:0], rx_data_pin};
      dcd_s_q <= {dcd_s_q[1:0], dcd_n_pin};
      if (clk_s_q[1] == clk_s_q[2]) rxc_q <= clk_s_q[2];
      if (dcd_s_q[1] == dcd_s_q[2]) dcd_q <= dcd_s_q[2];
    end
  end

  // Rising receive clock edge marks one bit time
  logic rxc_d1_q, bit_stb, dat_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxc_d1_q <= 1'b0;
      dat_q    <= 1'b0;
    end else begin
      rxc_d1_q <= rxc_q;
      if (dat_s_q[1] == dat_s_q[2]) dat_q <= dat_s_q[2];
    end
  end
  assign bit_stb = rxc_q & ~rxc_d1_q;

  // Registers
  logic [7:0]  ctrl_q, imode_q, vec_q;
  logic [15:0] sync_q;
  logic [1:0]  rxmode;
  logic        dcd_active;
  assign rxmode     = imode_q[IMODE_RXM_LO +: 2];
  assign dcd_active = ~dcd_q;

  // AHB-Lite address phase capture
  logic       wr_ph_q, rd_ph_q;
  logic [7:0] adr_q;
  logic       req;
  assign req = hsel & htrans[1] & hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      adr_q   <= 8'h00;
    end else begin
      wr_ph_q <= req & hwrite;
      rd_ph_q <= req & ~hwrite;
      if (req) adr_q <= haddr[7:0];
    end
  end

  logic wr_ctrl, wr_cmd, rd_data;
  assign wr_ctrl = wr_ph_q && adr_q == OFS_RX_CTRL;
  assign wr_cmd  = wr_ph_q && adr_q == OFS_COMMAND;
  assign rd_data = rd_ph_q && adr_q == OFS_RX_DATA;

  // Writable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= RST_CTRL;
      imode_q <= RST_IMODE;
      vec_q   <= RST_VECTOR;
      sync_q  <= RST_SYNC;
    end else if (wr_ph_q) begin
      case (adr_q)
        OFS_RX_CTRL:    ctrl_q  <= hwdata[7:0];
        OFS_INT_MODE:   imode_q <= hwdata[7:0];
        OFS_INT_VECTOR: if (SECOND_CHANNEL) vec_q <= hwdata[7:0];
        OFS_SYNC_CHARS: sync_q  <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  logic cmd_err, cmd_rearm, cmd_crc, cmd_ext, cmd_ack;
  assign cmd_err   = wr_cmd & hwdata[CMD_ERR_RESET];
  assign cmd_rearm = wr_cmd & hwdata[CMD_REARM_FIRST];
  assign cmd_crc   = wr_cmd & hwdata[CMD_CRC_RESET];
  assign cmd_ext   = wr_cmd & hwdata[CMD_EXT_RESET];
  assign cmd_ack   = wr_cmd & hwdata[CMD_INT_ACK];

  // Receiver gated by enable and, with auto-enables, by DCD
  logic rx_on, char_stb, in_hunt;
  rx_char_s new_char;
  assign rx_on = ctrl_q[CTRL_RX_EN] & (~ctrl_q[CTRL_AUTO_EN] | dcd_active);

  rx_shifter u_shift (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .bit_stb    (bit_stb),
    .rx_bit     (dat_q),
    .enable     (rx_on),
    .hunt_cmd   (wr_ctrl & hwdata[CTRL_HUNT]),
    .bisync     (ctrl_q[CTRL_BISYNC]),
    .sync_inhib (ctrl_q[CTRL_SYNC_INHIB]),
    .par_en     (1'b0),
    .par_odd    (1'b0),
    .sync_chars (sync_q),
    .char_stb   (char_stb),
    .char_out   (new_char),
    .in_hunt    (in_hunt)
  );

  // Three-deep receive FIFO
  rx_char_s   fifo_q [DEPTH];
  logic [1:0] cnt_q;
  logic       push, pop, ovr_evt;
  assign pop     = rd_data & (cnt_q != 2'd0);
  assign push    = char_stb;
  assign ovr_evt = push & (cnt_q == DEPTH[1:0]) & ~pop;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 2'd0;
      for (int i = 0; i < DEPTH; i++) fifo_q[i] <= '0;
    end else begin
      if (pop) begin
        for (int i = 0; i < DEPTH - 1; i++) fifo_q[i] <= fifo_q[i+1];
      end
      if (push) begin
        if (ovr_evt) fifo_q[DEPTH-1] <= new_char;
        else fifo_q[pop ? cnt_q - 2'd1 : cnt_q] <= new_char;
      end
      cnt_q <= cnt_q + {1'b0, push & ~ovr_evt} - {1'b0, pop};
    end
  end

  // CRC pipeline: a character is folded 8 bit times after loading
  logic [7:0] pend_q, crc_byte_q;
  logic       pend_v_q, crc_busy_q, crc_err_q;
  logic [3:0] bitn_q;
  logic [15:0] crc;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q     <= 8'h00;
      pend_v_q   <= 1'b0;
      crc_byte_q <= 8'h00;
      crc_busy_q <= 1'b0;
      bitn_q     <= 4'h0;
    end else begin
      if (push) begin
        // Previous word is committed with the CRC enable seen now
        pend_q     <= new_char.data;
        pend_v_q   <= 1'b1;
        crc_byte_q <= pend_q;
        crc_busy_q <= pend_v_q & ctrl_q[CTRL_CRC_EN];
        bitn_q     <= 4'h0;
      end else if (bit_stb && bitn_q < 4'(CRC_DELAY_BITS)) begin
        bitn_q <= bitn_q + 4'h1;
      end
      if (cmd_crc && !push) pend_v_q <= 1'b0; // New character wins over reset
    end
  end

  logic crc_shift;
  assign crc_shift = crc_busy_q & bit_stb & ~push & (bitn_q < 4'(CRC_DELAY_BITS));

  crc16_shift u_crc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (cmd_crc),
    .shift   (crc_shift),
    .din     (crc_byte_q[bitn_q[2:0]]),
    .crc     (crc)
  );

  // Comparison redone on each received character; shows check two characters back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) crc_err_q <= 1'b1;
    else if (push) crc_err_q <= (crc != 16'h0000);
  end

  // Latched errors, set wins over reset
  logic par_lat_q, ovr_lat_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      par_lat_q <= 1'b0;
      ovr_lat_q <= 1'b0;
    end else begin
      par_lat_q <= (par_lat_q & ~cmd_err) | (push & new_char.parity_err);
      ovr_lat_q <= (ovr_lat_q & ~cmd_err) | ovr_evt;
    end
  end

  // Interrupt sources
  logic first_arm_q, rx_pend_q, spec_pend_q, ext_pend_q, dcd_d_q;
  logic spec_evt, char_int;
  assign spec_evt = (ovr_evt | (push & new_char.parity_err & rxmode != RXM_FIRST
                    & rxmode != RXM_EVNP)) & (rxmode != RXM_NONE);
  assign char_int = push & ((rxmode == RXM_FIRST & first_arm_q)
                    | rxmode == RXM_EVERY | rxmode == RXM_EVNP);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_arm_q <= 1'b1;
      rx_pend_q   <= 1'b0;
      spec_pend_q <= 1'b0;
      ext_pend_q  <= 1'b0;
      dcd_d_q     <= 1'b1;
    end else begin
      dcd_d_q <= dcd_q;
      if (cmd_rearm) first_arm_q <= 1'b1;
      else if (char_int && rxmode == RXM_FIRST) first_arm_q <= 1'b0;
      rx_pend_q   <= char_int | (rx_pend_q & ~cmd_ack);
      spec_pend_q <= spec_evt | (spec_pend_q & ~cmd_ack & ~cmd_err);
      ext_pend_q  <= (imode_q[IMODE_EXT_EN] & (dcd_q ^ dcd_d_q))
                     | (ext_pend_q & ~cmd_ext);
    end
  end

  // Vector and outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q        <= 1'b0;
      vector_q     <= RST_VECTOR;
      wait_ready_q <= 1'b0;
    end else begin
      irq_q <= rx_pend_q | spec_pend_q | ext_pend_q;
      if (SECOND_CHANNEL && imode_q[IMODE_SAV]) begin
        vector_q <= {vec_q[7:4], spec_pend_q ? 3'b111 : ext_pend_q ? 3'b101
                     : rx_pend_q ? 3'b110 : 3'b011, vec_q[0]};
      end else begin
        vector_q <= vec_q;
      end
      // Every stored character raises wait/ready, the first one too, as first_arm_q clears when it is stored
      wait_ready_q <= imode_q[IMODE_WAIT_EN] & (cnt_q != 2'd0)
                      & (rxmode != RXM_FIRST | ~first_arm_q);
    end
  end

  // Read data
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      OFS_RX_DATA:    rd_mux = {24'h0, fifo_q[0].data};
      OFS_RX_STATUS:  rd_mux = {24'h0, 1'b0, crc_err_q, ovr_lat_q, par_lat_q, 4'h1};
      OFS_RX_CTRL:    rd_mux = {24'h0, ctrl_q};
      OFS_INT_MODE:   rd_mux = {24'h0, imode_q};
      OFS_INT_VECTOR: rd_mux = {24'h0, SECOND_CHANNEL ? vec_q : 8'h00};
      OFS_SYNC_CHARS: rd_mux = {16'h0, sync_q};
      OFS_CHAN_STAT:  rd_mux = {24'h0, 1'b0, dcd_active, in_hunt, first_arm_q,
                                1'b0, cnt_q, cnt_q != 2'd0};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero-wait AHB answer; read data registered from address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (req && !hwrite) hrdata <= rd_mux;
    end
  end

endmodule : sync_receive_irq_crc_check

// ---- shared/sync_rx_pkg.sv ----
// Shared constants, enums and carrier structs for the sync receive channel
package sync_rx_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_RX_DATA    = 8'h00;
  localparam logic [7:0] OFS_RX_STATUS  = 8'h04; // special_receive_status_reg
  localparam logic [7:0] OFS_RX_CTRL    = 8'h08; // receive_control_reg
  localparam logic [7:0] OFS_INT_MODE   = 8'h0c; // interrupt_mode_reg
  localparam logic [7:0] OFS_INT_VECTOR = 8'h10; // interrupt_vector_reg
  localparam logic [7:0] OFS_COMMAND    = 8'h14;
  localparam logic [7:0] OFS_SYNC_CHARS = 8'h18;
  localparam logic [7:0] OFS_CHAN_STAT  = 8'h1c;

  // receive_control_reg fields
  localparam int CTRL_RX_EN       = 0;
  localparam int CTRL_HUNT        = 4;
  localparam int CTRL_CRC_EN      = 3;
  localparam int CTRL_SYNC_INHIB  = 1;
  localparam int CTRL_AUTO_EN     = 5;
  localparam int CTRL_BISYNC      = 6;

  // interrupt_mode_reg fields
  localparam int IMODE_EXT_EN     = 0;
  localparam int IMODE_SAV        = 2;
  localparam int IMODE_RXM_LO     = 3;
  localparam int IMODE_PAR_SPEC   = 5;
  localparam int IMODE_WAIT_EN    = 7;

  // Receive interrupt modes
  localparam logic [1:0] RXM_NONE  = 2'b00;
  localparam logic [1:0] RXM_FIRST = 2'b01;
  localparam logic [1:0] RXM_EVERY = 2'b10;
  localparam logic [1:0] RXM_EVNP  = 2'b11;

  // Command register bits (write one to act)
  localparam int CMD_ERR_RESET    = 0;
  localparam int CMD_REARM_FIRST  = 1;
  localparam int CMD_CRC_RESET    = 2;
  localparam int CMD_EXT_RESET    = 3;
  localparam int CMD_INT_ACK      = 4;

  // special_receive_status_reg fields
  localparam int STAT_PARITY      = 4;
  localparam int STAT_OVERRUN     = 5;
  localparam int STAT_CRC_ERR     = 6;

  // Reset values and CRC-16 polynomial
  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [7:0]  RST_IMODE  = 8'h00;
  localparam logic [7:0]  RST_VECTOR = 8'h00;
  localparam logic [15:0] RST_SYNC   = 16'h1616;
  localparam logic [15:0] CRC_INIT   = 16'h0000;
  localparam logic [15:0] CRC16_POLY = 16'h8005; // x16+x15+x2+1

  // Timing, in receive bit times, and FIFO depth in characters
  localparam int CRC_DELAY_BITS   = 8;
  localparam int CRC_RESULT_BITS  = 16;
  localparam int FIFO_DEPTH       = 3;

  // Hunt/sync state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HUNT = 3'b010,
    ST_SYNC = 3'b100
  } rx_state_e;

  // A received character with its status
  typedef struct packed {
    logic [7:0] data;
    logic       parity_err;
    logic       crc_err;
  } rx_char_s;

endpackage : sync_rx_pkg

// ---- hw/crc16_shift.sv ----
// Serial CRC-16 checker that folds one delayed character bit by bit
`timescale 1ns/100ps
module crc16_shift
  import sync_rx_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clr,
  input  wire logic        shift,
  input  wire logic        din,
  output logic [15:0]      crc
);

  logic [15:0] crc_q;
  logic        fb;

  assign fb  = crc_q[15] ^ din;
  assign crc = crc_q;

  // One CRC-16 step per included bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_q <= CRC_INIT;
    end else if (clr) begin
      crc_q <= CRC_INIT;
    end else if (shift) begin
      crc_q <= {crc_q[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
    end
  end

endmodule : crc16_shift

// ---- hw/rx_shifter.sv ----
// Receive shift register with sync hunt, parity check and sync inhibit
`timescale 1ns/100ps
module rx_shifter
  import sync_rx_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        bit_stb,
  input  wire logic        rx_bit,
  input  wire logic        enable,
  input  wire logic        hunt_cmd,
  input  wire logic        bisync,
  input  wire logic        sync_inhib,
  input  wire logic        par_en,
  input  wire logic        par_odd,
  input  wire logic [15:0] sync_chars,
  output logic             char_stb,
  output rx_char_s         char_out,
  output logic             in_hunt
);

  rx_state_e   st_q;
  logic [15:0] sh_q;
  logic [3:0]  cnt_q;
  logic        par_q;
  logic        data_seen_q;
  logic [15:0] sh_d;
  logic        sync_hit;
  logic        bad_par;

  assign sh_d     = {rx_bit, sh_q[15:1]};
  assign sync_hit = bisync ? (sh_d == sync_chars) : (sh_d[15:8] == sync_chars[7:0]);
  assign bad_par  = par_en & ((^sh_d[15:8]) ^ par_odd ^ par_q) ;
  assign in_hunt  = (st_q != ST_SYNC);

  // Hunt until the sync pattern is seen, then frame characters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q        <= ST_IDLE;
      sh_q        <= 16'h0000;
      cnt_q       <= 4'h0;
      data_seen_q <= 1'b0;
      char_stb    <= 1'b0;
      char_out    <= '0;
    end else begin
      char_stb <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (enable) st_q <= ST_HUNT;
        end
        ST_HUNT: begin
          if (!enable) begin
            st_q <= ST_IDLE;
          end else if (bit_stb) begin
            sh_q <= sh_d;
            if (sync_hit) begin
              st_q        <= ST_SYNC;
              cnt_q       <= 4'h0;
              data_seen_q <= 1'b0;
            end
          end
        end
        ST_SYNC: begin
          if (!enable) begin
            st_q <= ST_IDLE;
          end else if (hunt_cmd) begin
            st_q <= ST_HUNT;
          end else if (bit_stb) begin
            sh_q  <= sh_d;
            cnt_q <= (cnt_q == 4'h7) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              // Leading syncs are dropped while inhibit is on
              if (!(sync_inhib && !data_seen_q && sh_d[15:8] == sync_chars[7:0])) begin
                char_stb            <= 1'b1;
                data_seen_q         <= 1'b1;
                char_out.data       <= sh_d[15:8];
                char_out.parity_err <= bad_par;
                char_out.crc_err    <= 1'b0;
              end
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Parity bit is not framed separately; seed from a fixed zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) par_q <= 1'b0;
    else          par_q <= 1'b0;
  end

endmodule : rx_shifter

// ---- test/sync_rx_chk.sv ----
// Port-level checks for the sync receive channel
`timescale 1ns/100ps
module sync_rx_chk
  import sync_rx_pkg::*;
#(
  parameter bit SECOND_CHANNEL = 1'b1
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        dcd_n_pin,
  input wire logic        irq_q,
  input wire logic        wait_ready_q
);
  logic       take;
  logic       wr_q;
  logic [7:0] adr_q;
  logic [7:0] imode_q;
  logic [7:0] vec_q;
  // Address phase accepted by the slave
  assign take = hsel && htrans[1] && hready;
  // Write address phase held for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      wr_q  <= take && hwrite;
      adr_q <= haddr[7:0];
    end
  end
  // Shadow copies of mode and vector registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imode_q <= RST_IMODE;
      vec_q   <= RST_VECTOR;
    end else if (wr_q) begin
      if (adr_q == OFS_INT_MODE) imode_q <= hwdata[7:0];
      if (adr_q == OFS_INT_VECTOR) vec_q <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bus answers
  ready_always_a: assert property (hreadyout)
    else $error("hreadyout low");
  okay_resp_a: assert property (!hresp)
    else $error("hresp not okay");
  rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved without a read");
  unmapped_zero_a: assert property (take && !hwrite && haddr[7:0] > OFS_CHAN_STAT |=> hrdata == 0)
    else $error("unmapped read not zero");
  vector_read_a: assert property (
    take && !hwrite && haddr[7:0] == OFS_INT_VECTOR
    |=> hrdata[7:0] == (SECOND_CHANNEL ? $past(vec_q) : 8'h00))
    else $error("vector readback wrong");
  // Interrupt and handshake sources
  quiet_irq_a: assert property ($rose(irq_q) |-> imode_q[4:3] != RXM_NONE || imode_q[0])
    else $error("interrupt with all sources off");
  dma_gate_a: assert property ($rose(wait_ready_q) |-> imode_q[IMODE_WAIT_EN])
    else $error("wait/ready without enable");
  dcd_irq_a: assert property (imode_q[IMODE_EXT_EN] && $changed(dcd_n_pin) |-> ##[1:8] irq_q)
    else $error("carrier change gave no interrupt");
  cover property ($rose(irq_q));
  cover property ($rose(wait_ready_q));
  cover property (take && !hwrite && haddr[7:0] == OFS_RX_STATUS);
endmodule : sync_rx_chk

bind sync_receive_irq_crc_check sync_rx_chk #(.SECOND_CHANNEL(SECOND_CHANNEL)) sync_rx_chk_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .dcd_n_pin(dcd_n_pin), .irq_q(irq_q),
  .wait_ready_q(wait_ready_q));

// ---- test/sync_link_model.sv ----
// Remote synchronous transmitter on the receive pins
`timescale 1ns/100ps
module sync_link_model
  import sync_rx_pkg::*;
(
  output logic receive_clock_pin,
  output logic rx_data_pin,
  output logic dcd_n_pin
);
  logic [15:0] crc_q;
  // Idle line, clock parked low, carrier present
  initial begin
    receive_clock_pin = 1'b0;
    rx_data_pin       = 1'b1;
    dcd_n_pin         = 1'b0;
    crc_q             = CRC_INIT;
  end
  // Data set while clock is low, taken at its rise
  task automatic send_bit(input logic b);
    rx_data_pin = b;
    #32 receive_clock_pin = 1'b1;
    #32 receive_clock_pin = 1'b0;
  endtask : send_bit
  // One character, low bit first, clock runs only inside it
  task automatic send_byte(input logic [7:0] b, input bit inc);
    #1.3;
    for (int i = 0; i < 8; i++) begin
      if (inc) crc_q = {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ b[i]) ? CRC16_POLY : 16'h0000);
      send_bit(b[i]);
    end
    rx_data_pin = ~rx_data_pin; // Released line shows no stale bit
  endtask : send_byte
  task automatic set_dcd(input logic v);
    dcd_n_pin = v;
  endtask : set_dcd
  task automatic crc_clear;
    crc_q = CRC_INIT;
  endtask : crc_clear
endmodule : sync_link_model

// ---- test/sync_receive_irq_crc_check_tb.sv ----
// Self-checking bench for the sync receive channel
`timescale 1ns/100ps
module sync_receive_irq_crc_check_tb
  import sync_rx_pkg::*;
;
  localparam logic [31:0] RX_RUN = 32'h1 << CTRL_RX_EN | 32'h1 << CTRL_SYNC_INHIB
                                   | 32'h1 << CTRL_BISYNC;
  localparam logic [31:0] EVERY  = 32'(RXM_EVERY) << IMODE_RXM_LO;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        rx_clk;
  logic        rx_dat;
  logic        dcd_n;
  logic        irq;
  logic        dma_rdy;
  logic [7:0]  vec;
  int          fail_count;
  int          tests_run;
  int          cyc;

  sync_receive_irq_crc_check #(.SECOND_CHANNEL(1'b1), .DEPTH(FIFO_DEPTH))
    sync_receive_irq_crc_check_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .receive_clock_pin(rx_clk), .rx_data_pin(rx_dat),
    .dcd_n_pin(dcd_n), .irq_q(irq), .vector_q(vec), .wait_ready_q(dma_rdy));
  sync_link_model sync_link_model_inst (
    .receive_clock_pin(rx_clk), .rx_data_pin(rx_dat), .dcd_n_pin(dcd_n));

  // Clock and hang guard
  always #2 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Single word transfer, read data left in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic cmd(input int b);
    ahb(1'b1, OFS_COMMAND, 32'h1 << b);
  endtask : cmd

  task automatic send(input logic [7:0] b, input bit inc);
    sync_link_model_inst.send_byte(b, inc);
  endtask : send

  // Give the interrupt a bounded time to show, then compare
  task automatic irq_wait(input logic exp);
    int n;
    n = 0;
    // Registered irq lags an acknowledge by two edges
    repeat (3) @(posedge hclk);
    while (irq !== 1'b1 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask : irq_wait

  // Serve one character interrupt: status, data, acknowledge
  task automatic take_char(output logic [31:0] st, output logic [31:0] d);
    irq_wait(1'b1);
    ahb(1'b0, OFS_RX_STATUS, 0);
    st = rd;
    ahb(1'b0, OFS_RX_DATA, 0);
    d = rd;
    cmd(CMD_INT_ACK);
  endtask : take_char

  task automatic t_regs;
    ahb(1'b0, OFS_RX_CTRL, 0);
    chk("ctrl", {24'h0, RST_CTRL}, rd);
    ahb(1'b0, OFS_SYNC_CHARS, 0);
    chk("sync", {16'h0, RST_SYNC}, rd);
    ahb(1'b0, 8'h20, 0);
    chk("unmapped", 0, rd);
    ahb(1'b1, OFS_INT_VECTOR, 32'h5a);
    ahb(1'b0, OFS_INT_VECTOR, 0);
    chk("vector", 32'h5a, rd);
    chk("vector pin", 32'h5a, {24'h0, vec});
  endtask : t_regs

  task automatic t_every;
    logic [31:0] st;
    logic [31:0] d;
    ahb(1'b1, OFS_RX_CTRL, RX_RUN | 32'h1 << CTRL_HUNT);
    for (int i = 0; i < 3; i++) send(8'h16, 1'b0);
    send(8'h3c, 1'b0);
    irq_wait(1'b0);
    ahb(1'b0, OFS_RX_DATA, 0);
    chk("data", 32'h3c, rd);
    ahb(1'b1, OFS_INT_MODE, EVERY);
    for (int i = 0; i < 2; i++) begin
      send(8'h81 + i, 1'b0);
      take_char(st, d);
      chk("data", 32'h81 + i, d);
    end
    irq_wait(1'b0);
  endtask : t_every

  task automatic t_first;
    ahb(1'b1, OFS_INT_MODE, 32'(RXM_FIRST) << IMODE_RXM_LO | 32'h1 << IMODE_WAIT_EN);
    send(8'ha1, 1'b0);
    irq_wait(1'b1);
    cmd(CMD_INT_ACK);
    send(8'ha2, 1'b0);
    irq_wait(1'b0);
    chk("dma", 1, {31'h0, dma_rdy});
    send(8'ha3, 1'b0);
    send(8'ha4, 1'b0);
    irq_wait(1'b1);
    ahb(1'b0, OFS_RX_STATUS, 0);
    chk("overrun", 1, {31'h0, rd[STAT_OVERRUN]});
    cmd(CMD_INT_ACK);
    ahb(1'b0, OFS_RX_DATA, 0);
    chk("data", 32'ha1, rd);
    ahb(1'b0, OFS_RX_STATUS, 0);
    chk("overrun", 1, {31'h0, rd[STAT_OVERRUN]});
    cmd(CMD_ERR_RESET);
    ahb(1'b0, OFS_RX_STATUS, 0);
    chk("overrun", 0, {31'h0, rd[STAT_OVERRUN]});
    ahb(1'b0, OFS_RX_DATA, 0);
    ahb(1'b0, OFS_RX_DATA, 0);
    cmd(CMD_REARM_FIRST);
    send(8'ha5, 1'b0);
    irq_wait(1'b1);
    ahb(1'b0, OFS_RX_DATA, 0);
    chk("data", 32'ha5, rd);
    cmd(CMD_INT_ACK);
  endtask : t_first

  task automatic t_dcd;
    ahb(1'b1, OFS_INT_MODE, 32'h1 << IMODE_EXT_EN);
    for (int i = 0; i < 2; i++) begin
      sync_link_model_inst.set_dcd(i == 0);
      irq_wait(1'b1);
      cmd(CMD_EXT_RESET);
      cmd(CMD_INT_ACK);
      irq_wait(1'b0);
    end
  endtask : t_dcd

  // Good and corrupted check words; flag read three characters later
  task automatic t_crc;
    logic [31:0] st;
    logic [31:0] d;
    logic [15:0] w;
    logic [15:0] r;
    for (int k = 0; k < 2; k++) begin
      // Second pass runs the every-character mode without parity special
      ahb(1'b1, OFS_INT_MODE, 32'(k == 0 ? RXM_EVERY : RXM_EVNP) << IMODE_RXM_LO);
      cmd(CMD_CRC_RESET);
      sync_link_model_inst.crc_clear();
      ahb(1'b1, OFS_RX_CTRL, RX_RUN | 32'h1 << CTRL_CRC_EN);
      for (int i = 0; i < 3; i++) begin
        send(8'h41 + i, 1'b1);
        take_char(st, d);
      end
      w = sync_link_model_inst.crc_q ^ 16'(k);
      for (int j = 0; j < 16; j++) r[j] = w[15 - j];
      send(r[7:0], 1'b0);
      take_char(st, d);
      send(r[15:8], 1'b0);
      take_char(st, d);
      send(8'hff, 1'b0);
      take_char(st, d);
      ahb(1'b1, OFS_RX_CTRL, RX_RUN);
      for (int i = 0; i < 2; i++) begin
        send(8'hff, 1'b0);
        take_char(st, d);
      end
      chk("crc flag", 32'(k), {31'h0, st[STAT_CRC_ERR]});
    end
  endtask : t_crc

  // Reset, then the scenarios in turn
  initial begin
    hclk       = 1'b0;
    hresetn    = 1'b0;
    hsel       = 1'b0;
    hwrite     = 1'b0;
    htrans     = 2'b00;
    hsize      = 3'b010;
    haddr      = 32'h0;
    hwdata     = 32'h0;
    fail_count = 0;
    tests_run  = 0;
    cyc        = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_every();
    t_first();
    t_dcd();
    t_crc();
    complete_run();
  end
endmodule : sync_receive_irq_crc_check_tb
